// [rtl/rcs_reset_clock_ctrl.sv]
`timescale 1ns/1ns
`include "rcs_params.svh"
module rcs_reset_clock_ctrl (
   input  wire logic                clk,
   input  wire logic                sys_rst,
   input  wire rcs_pkg::rcs_causes_s causes,
   input  wire logic                supply_monitor_enable_pin,
   input  wire logic                adc2_convert_start_pin,
   input  wire logic                rst_pin_n_in,
   input  wire logic                en_watchdog,
   input  wire logic                en_missing_clk,
   input  wire logic                en_comp_level,
   input  wire logic                en_software,
   input  wire logic                en_conv_start,
   input  wire logic                wdt_lock_req,
   input  wire logic                wdt_disable_req,
   input  wire rcs_pkg::rcs_clk_src_e clk_src_req,
   output logic                     rst_pin_n_out,
   output logic                     rst_pin_oe,
   output logic                     system_reset,
   output logic                     wdt_enabled,
   output logic                     wdt_locked,
   output rcs_pkg::rcs_clk_src_e    clk_src,
   output rcs_pkg::rcs_vec_t        last_cause
);
   import rcs_pkg::*;

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   // Two stages per pin; only stage two is read by logic
   logic [2:0] sync1_r, sync1_nxt;
   logic [2:0] sync2_r, sync2_nxt;

   always_comb begin
      sync1_nxt = {supply_monitor_enable_pin, adc2_convert_start_pin,
                   ~rst_pin_n_in};
      sync2_nxt = sync1_r;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync1_r <= 3'h0;
         sync2_r <= 3'h0;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
      end
   end

   logic mon_en_s;
   logic conv_s;
   logic pin_low_s;
   assign mon_en_s  = sync2_r[2];
   assign conv_s    = sync2_r[1];
   assign pin_low_s = sync2_r[0];

   // ----------------------------------------------------------------------
   // Power-on timer and pin drive
   // ----------------------------------------------------------------------
   // Pin only driven by the power-on pulse; an outside low pulls it too,
   // so our own drive is masked from the pin cause below to avoid lock-up
   localparam int POR_W = $clog2(`RCS_POR_CYC + 1);
   localparam logic [POR_W-1:0] POR_MAX = POR_W'(`RCS_POR_CYC);
   logic [POR_W-1:0] por_cnt_r, por_cnt_nxt;
   logic             por_act_r, por_act_nxt;
   logic             oe_r, oe_nxt;
   logic             oe_d1_r, oe_d2_r, oe_d3_r;

   always_comb begin
      por_cnt_nxt = por_cnt_r;
      por_act_nxt = por_act_r;
      if (por_act_r) begin
         if (por_cnt_r == POR_MAX) begin
            por_act_nxt = 1'b0;
         end else begin
            por_cnt_nxt = por_cnt_r + POR_W'(1);
         end
      end
      oe_nxt = por_act_nxt;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         por_cnt_r <= '0;
         por_act_r <= 1'b1;
         oe_r      <= 1'b1;
         oe_d1_r   <= 1'b1;
         oe_d2_r   <= 1'b1;
         oe_d3_r   <= 1'b1;
      end else begin
         por_cnt_r <= por_cnt_nxt;
         por_act_r <= por_act_nxt;
         oe_r      <= oe_nxt;
         oe_d1_r   <= oe_r;
         oe_d2_r   <= oe_d1_r;
         oe_d3_r   <= oe_d2_r;
      end
   end

   // ----------------------------------------------------------------------
   // Cause gating and combination
   // ----------------------------------------------------------------------
   logic [`RCS_NUM_CAUSES-1:0] active;
   logic                       own_drive;
   assign own_drive = oe_r | oe_d1_r | oe_d2_r | oe_d3_r;

   always_comb begin
      active = '0;
      active[`RCS_C_SUPPLY]    = causes.supply & mon_en_s;
      active[`RCS_C_WATCHDOG]  = causes.watchdog & wdt_enabled;
      active[`RCS_C_MISSCLK]   = causes.missing_clk & en_missing_clk;
      active[`RCS_C_COMP]      = causes.comp_level & en_comp_level;
      active[`RCS_C_SOFTWARE]  = causes.software & en_software;
      active[`RCS_C_CONVSTART] = (causes.conv_start | conv_s)
                                 & en_conv_start;
      active[`RCS_C_PIN]       = (causes.pin | pin_low_s)
                                 & ~own_drive;
   end

   // ----------------------------------------------------------------------
   // System reset, stretch and cause capture
   // ----------------------------------------------------------------------
   // Short stretch after the last cause so downstream sees a clean pulse
   localparam logic [2:0] STR_MAX = 3'(`RCS_STRETCH_CYC);
   logic       any_cause;
   logic [2:0] str_r, str_nxt;
   logic       rst_r, rst_nxt;
   rcs_vec_t   cause_r, cause_nxt;
   assign any_cause = |active | por_act_r;

   always_comb begin
      str_nxt   = str_r;
      cause_nxt = cause_r;
      if (any_cause) begin
         str_nxt   = STR_MAX;
         cause_nxt = active;
      end else if (str_r != 3'h0) begin
         str_nxt = str_r - 3'h1;
      end
      rst_nxt = any_cause | (str_nxt != 3'h0);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         str_r   <= STR_MAX;
         rst_r   <= 1'b1;
         cause_r <= `RCS_EN_RST;
      end else begin
         str_r   <= str_nxt;
         rst_r   <= rst_nxt;
         cause_r <= cause_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Watchdog enable, lock, clock source
   // ----------------------------------------------------------------------
   // Lock survives system resets except power-on, only sys_rst clears it
   logic         wdt_en_r, wdt_en_nxt;
   logic         lock_r, lock_nxt;
   rcs_clk_src_e src_r, src_nxt;

   always_comb begin
      lock_nxt   = lock_r | wdt_lock_req;
      wdt_en_nxt = lock_nxt | (en_watchdog & ~wdt_disable_req);
      src_nxt    = clk_src_req;
      if (rst_r) begin
         src_nxt = RCS_SRC_INTERNAL;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wdt_en_r <= 1'b0;
         lock_r   <= 1'b0;
         src_r    <= RCS_SRC_INTERNAL;
      end else begin
         wdt_en_r <= wdt_en_nxt;
         lock_r   <= lock_nxt;
         src_r    <= src_nxt;
      end
   end

   assign rst_pin_n_out = 1'b0;
   assign rst_pin_oe    = oe_r;
   assign system_reset  = rst_r;
   assign wdt_enabled   = wdt_en_r;
   assign wdt_locked    = lock_r;
   assign clk_src       = src_r;
   assign last_cause    = cause_r;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   sequence s_cause_seen;
      any_cause;
   endsequence
   sequence s_quiet;
      !any_cause [*5];
   endsequence

   property p_any_resets;
      @(posedge clk) disable iff (sys_rst) s_cause_seen |=> rst_r;
   endproperty
   a_any_resets: assert property (p_any_resets)
      else $error("cause did not reset system");

   property p_pin_resets;
      @(posedge clk) disable iff (sys_rst)
         (pin_low_s && !own_drive) |=> rst_r;
   endproperty
   a_pin_resets: assert property (p_pin_resets)
      else $error("external pin low did not reset");

   property p_disabled_sw;
      @(posedge clk) disable iff (sys_rst)
         (causes.software && !en_software) |-> !active[`RCS_C_SOFTWARE];
   endproperty
   a_disabled_sw: assert property (p_disabled_sw)
      else $error("disabled software cause active");

   property p_supply_gate;
      @(posedge clk) disable iff (sys_rst)
         (causes.supply && mon_en_s) |=> rst_r;
   endproperty
   a_supply_gate: assert property (p_supply_gate)
      else $error("enabled supply monitor ignored");

   property p_lock_holds;
      @(posedge clk) disable iff (sys_rst) lock_r |=> (lock_r && wdt_en_r);
   endproperty
   a_lock_holds: assert property (p_lock_holds)
      else $error("locked watchdog turned off");

   property p_internal_after;
      @(posedge clk) disable iff (sys_rst) rst_r |=> src_r == RCS_SRC_INTERNAL;
   endproperty
   a_internal_after: assert property (p_internal_after)
      else $error("clock not internal during reset");

   property p_switch;
      @(posedge clk) disable iff (sys_rst)
         (!rst_r && !any_cause) |=> (src_r == $past(clk_src_req) && !rst_r);
   endproperty
   a_switch: assert property (p_switch)
      else $error("clock switch failed or caused reset");

   property p_release;
      @(posedge clk) disable iff (sys_rst) s_quiet |=> !rst_r;
   endproperty
   a_release: assert property (p_release)
      else $error("reset not released after causes cleared");
endmodule : rcs_reset_clock_ctrl

// [shared/rcs_params.svh]
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH

// ----------------------------------------------------------------------
// Cause positions in the cause vector
// ----------------------------------------------------------------------
`define RCS_NUM_CAUSES    7
`define RCS_C_SUPPLY      0
`define RCS_C_WATCHDOG    1
`define RCS_C_MISSCLK     2
`define RCS_C_COMP        3
`define RCS_C_SOFTWARE    4
`define RCS_C_CONVSTART   5
`define RCS_C_PIN         6

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define RCS_EN_RST        7'h00
`define RCS_POR_NS        1000
`define RCS_CLK_NS        20
`define RCS_POR_CYC       ((`RCS_POR_NS + `RCS_CLK_NS - 1) / `RCS_CLK_NS)
`define RCS_STRETCH_CYC   4

`endif

// [shared/rcs_pkg.sv]
package rcs_pkg;
   typedef enum logic {
      RCS_SRC_INTERNAL,
      RCS_SRC_EXTERNAL
   } rcs_clk_src_e;

   // Raw reset causes from the device
   typedef struct packed {
      logic pin;
      logic conv_start;
      logic software;
      logic comp_level;
      logic missing_clk;
      logic watchdog;
      logic supply;
   } rcs_causes_s;

   typedef logic [6:0] rcs_vec_t;
endpackage : rcs_pkg

// [sim/rcs_far_side.sv]
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Board side of the two-way reset wire
// ---------------------------------------------------------------
module rcs_far_side (
   input  wire logic ext_rst_req,
   input  wire logic dev_oe,
   input  wire logic dev_level,
   output logic      wire_level
);
   // Pull-up wins only when neither party pulls the wire low
   assign wire_level = (dev_oe ? dev_level : 1'b1) & ~ext_rst_req;
endmodule : rcs_far_side

// [sim/tb.sv]
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Bench for the reset and clock source controller
// ---------------------------------------------------------------
module tb;
   import rcs_pkg::*;
   logic         clk, sys_rst, mon_pin, conv_pin, ext_rst, pin_wire;
   logic         en_wd, en_mc, en_cl, en_sw, en_cs, lock_req, dis_req;
   logic         pin_out, pin_oe, sys_r, wd_en, wd_lk;
   rcs_causes_s  causes;
   rcs_clk_src_e src_req, src;
   rcs_vec_t     last;
   int           errors, compares, cycles;

   rcs_reset_clock_ctrl rcs_reset_clock_ctrl_inst (.clk(clk),
      .sys_rst(sys_rst), .causes(causes),
      .supply_monitor_enable_pin(mon_pin),
      .adc2_convert_start_pin(conv_pin), .rst_pin_n_in(pin_wire),
      .en_watchdog(en_wd), .en_missing_clk(en_mc), .en_comp_level(en_cl),
      .en_software(en_sw), .en_conv_start(en_cs), .wdt_lock_req(lock_req),
      .wdt_disable_req(dis_req), .clk_src_req(src_req),
      .rst_pin_n_out(pin_out), .rst_pin_oe(pin_oe), .system_reset(sys_r),
      .wdt_enabled(wd_en), .wdt_locked(wd_lk), .clk_src(src),
      .last_cause(last));
   rcs_far_side rcs_far_side_inst (.ext_rst_req(ext_rst), .dev_oe(pin_oe),
      .dev_level(pin_out), .wire_level(pin_wire));

   // Free-running clock and a cycle ceiling against hangs
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         close_out;
      end
   end

   task close_out;
      if (errors == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out

   task chk(input string n, input logic [6:0] e, input logic [6:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // Bounded wait; the power-on pulse is the longest hold
   task wait_idle;
      for (int i = 0; i < 80 && sys_r !== 1'b0; i++) @(negedge clk);
      chk("release", 7'h00, {6'h00, sys_r});
   endtask : wait_idle

   // Monitor pin crosses two sync stages; let it settle before use
   task set_en(input logic v);
      @(posedge clk);
      {en_wd, en_mc, en_cl, en_sw, en_cs, mon_pin} <= {6{v}};
      repeat (3) @(posedge clk);
   endtask : set_en

   // Raise causes, judge, drop them, wait for release
   task hit(input rcs_vec_t c, input logic cv, input logic ex,
            input logic exp_rst);
      @(posedge clk);
      causes <= rcs_causes_s'(c);
      conv_pin <= cv;
      ext_rst <= ex;
      repeat (5) @(negedge clk);
      chk("system_reset", {6'h00, exp_rst}, {6'h00, sys_r});
      if (exp_rst && !cv && !ex) chk("last_cause", c, last);
      @(posedge clk);
      causes <= '0;
      conv_pin <= 1'b0;
      ext_rst <= 1'b0;
      wait_idle;
   endtask : hit

   task s_power_on;
      @(negedge clk);
      chk("oe", 7'h01, {6'h00, pin_oe});
      chk("wire", 7'h00, {6'h00, pin_wire});
      chk("clk_src", 7'h00, {6'h00, src});
      wait_idle;
      chk("wire idle", 7'h01, {6'h00, pin_wire});
   endtask : s_power_on

   // Each gated cause enabled, then each disabled; pins last, the ungated reset pin once with enables off
   task s_causes;
      for (int i = 0; i < 5; i++) hit(7'h01 << i, 1'b0, 1'b0, 1'b1);
      hit(7'h00, 1'b1, 1'b0, 1'b1);
      set_en(1'b0);
      for (int i = 0; i < 5; i++) hit(7'h01 << i, 1'b0, 1'b0, 1'b0);
      hit(7'h00, 1'b1, 1'b0, 1'b0);
      hit(7'h00, 1'b0, 1'b1, 1'b1);
      set_en(1'b1);
   endtask : s_causes

   // Two causes overlap; reset holds until the later one leaves
   task s_overlap;
      @(posedge clk);
      causes <= rcs_causes_s'(7'h12);
      repeat (3) @(posedge clk);
      causes <= rcs_causes_s'(7'h10);
      repeat (6) @(negedge clk);
      chk("held", 7'h01, {6'h00, sys_r});
      @(posedge clk);
      causes <= '0;
      repeat (2) @(negedge clk);
      chk("stretch", 7'h01, {6'h00, sys_r});
      wait_idle;
   endtask : s_overlap

   task s_lock;
      @(posedge clk);
      dis_req <= 1'b1;
      repeat (3) @(negedge clk);
      chk("wdt off", 7'h00, {6'h00, wd_en});
      @(posedge clk);
      lock_req <= 1'b1;
      @(posedge clk);
      lock_req <= 1'b0;
      en_wd <= 1'b0;
      repeat (3) @(negedge clk);
      chk("wdt lock", 7'h03, {5'h00, wd_lk, wd_en});
   endtask : s_lock

   // Live switch to external, then a reset forces internal
   task s_clock;
      @(posedge clk);
      src_req <= RCS_SRC_EXTERNAL;
      repeat (2) @(negedge clk);
      chk("switch", 7'h02, {5'h00, src, sys_r});
      @(posedge clk);
      causes <= rcs_causes_s'(7'h04);
      repeat (4) @(negedge clk);
      chk("after reset", 7'h01, {5'h00, src, sys_r});
      @(posedge clk);
      causes <= '0;
      wait_idle;
   endtask : s_clock

   initial begin
      {sys_rst, conv_pin, ext_rst, lock_req, dis_req} = 5'h10;
      {en_wd, en_mc, en_cl, en_sw, en_cs, mon_pin} = 6'h3F;
      causes = '0;
      src_req = RCS_SRC_INTERNAL;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      s_power_on;
      s_causes;
      s_overlap;
      s_clock;
      s_lock;
      close_out;
   end
endmodule : tb
